// [design/hfr_rx_port.v]
// Receive half of the byte-wide buffered host port with strap decode
`timescale 1ns/1ns
`include "hfr_regs.vh"
module hfr_rx_port (
    input wire clk,                         // 10 MHz system clock
    input wire sys_rst,                     // Synchronous reset, high
    input wire host_ref_clock,              // Host reference clock pin
    input wire host_read_strobe_n,          // Read strobe pin
    input wire host_write_strobe_n,         // Write strobe pin
    input wire port_select_n,               // Chip select pin
    input wire tx_session_enable,           // Host transmit session pin
    input wire [7:0] host_byte_bus_in,      // Data bus input level
    output reg [7:0] host_byte_bus_out,     // Data bus drive value
    output wire host_byte_bus_oe_n,         // Bus enable, low drives
    output reg rx_frame_valid,              // Frame ready for host
    output reg tx_in_progress,              // Transmit session running
    input wire [`HFR_DEB_W-1:0] deb_count,  // Debounce length, ref periods
    input wire frame_ready,                 // Demodulator has a frame
    input wire [`HFR_LEN_W-1:0] frame_len,  // Payload length of that frame
    input wire [7:0] frame_byte,            // Payload byte at frame_idx
    output reg [`HFR_LEN_W-1:0] frame_idx,  // Payload byte index
    output reg frame_done,                  // Pulse: frame fully read
    output reg [7:0] tx_byte,               // Written byte
    output reg tx_byte_valid,               // Pulse with tx_byte
    input wire tx_busy,                     // Transmitter still draining
    input wire [2:0] strap_pins,            // Interface straps 1st..3rd
    output reg [2:0] ul_mode                // Selected upper-layer mode
);
    // One-hot sequencer states
    localparam ST_IDLE = 3'b001;
    localparam ST_GAP = 3'b010;
    localparam ST_SEND = 3'b100;
    // Gap length in system clocks, rounded down from the nominal time;
    // the idle cycle and the valid register make up the fraction
    localparam [31:0] IFG_FULL = `HFR_IFG_CYC;
    localparam [9:0] IFG_CYC = IFG_FULL[9:0];

    reg [2:0] state_r;
    reg [9:0] gap_r;
    reg [`HFR_LEN_W+1:0] pos_r;
    reg [1:0] sel_sync_r;
    reg [1:0] txen_sync_r;
    reg [2:0] strap_s1_r;
    reg [2:0] strap_s2_r;
    reg [7:0] din_s1_r;
    reg [7:0] din_s2_r;
    reg strap_taken_r;
    reg [1:0] strap_wait_r;
    // Debounced release pulses of the two strobes
    wire rd_rise;
    wire wr_rise;
    wire [`HFR_LEN_W+1:0] total;

    // Map strap levels to an interface mode
    function [2:0] strap_mode;
        input [2:0] s;
        begin
            case (s)
                `HFR_STRAP_MII: strap_mode = `HFR_MODE_MII;
                `HFR_STRAP_RMII: strap_mode = `HFR_MODE_RMII;
                `HFR_STRAP_USB: strap_mode = `HFR_MODE_USB;
                default: strap_mode = `HFR_MODE_NONE;
            endcase
        end
    endfunction

    hfr_strobe_deb u_rd (
        .clk(clk),
        .sys_rst(sys_rst),
        .host_ref_clock(host_ref_clock),
        .strobe_n(host_read_strobe_n),
        .deb_count(deb_count),
        .level_r(),
        .rise_r(rd_rise)
    );

    hfr_strobe_deb u_wr (
        .clk(clk),
        .sys_rst(sys_rst),
        .host_ref_clock(host_ref_clock),
        .strobe_n(host_write_strobe_n),
        .deb_count(deb_count),
        .level_r(),
        .rise_r(wr_rise)
    );

    // Pin synchronisers for select, enable, straps and write data
    // Write data needs no gray code: the host holds it steady across the
    // whole debounce window, so both stages settle before it is used
    always @(posedge clk) begin
        if (sys_rst) begin
            sel_sync_r <= 2'b11;
            txen_sync_r <= 2'b00;
            strap_s1_r <= 3'h7;
            strap_s2_r <= 3'h7;
            din_s1_r <= 8'h00;
            din_s2_r <= 8'h00;
        end else begin
            sel_sync_r <= {sel_sync_r[0], port_select_n};
            txen_sync_r <= {txen_sync_r[0], tx_session_enable};
            strap_s1_r <= strap_pins;
            strap_s2_r <= strap_s1_r;
            din_s1_r <= host_byte_bus_in;
            din_s2_r <= din_s1_r;
        end
    end

    // Straps caught once after reset release, then held. The
    // synchroniser is set to 3'h7 by reset, so wait two clocks for the
    // pin level to reach its second stage before taking it; taking
    // it at once would latch the reset filler instead of the straps
    always @(posedge clk) begin
        if (sys_rst) begin
            strap_taken_r <= 1'b0;
            strap_wait_r <= 2'b00;
            ul_mode <= `HFR_MODE_NONE;
        end else if (!strap_taken_r) begin
            if (strap_wait_r == 2'b10) begin
                strap_taken_r <= 1'b1;
                ul_mode <= strap_mode(strap_s2_r);
            end else begin
                strap_wait_r <= strap_wait_r + 2'b01;
            end
        end
    end

    // Drive the bus only while select and read are low at the pins;
    // combinational so release is immediate and never fights the host
    assign host_byte_bus_oe_n = port_select_n | host_read_strobe_n;

    // Transmit session: busy follows enable while no frame is valid and lasts until drained
    // A write counts only inside a session with the select low
    always @(posedge clk) begin
        if (sys_rst) begin
            tx_in_progress <= 1'b0;
            tx_byte <= 8'h00;
            tx_byte_valid <= 1'b0;
        end else begin
            tx_byte_valid <= 1'b0;
            if (txen_sync_r[1] && !rx_frame_valid) begin
                tx_in_progress <= 1'b1;
            end else if (!txen_sync_r[1] && !tx_busy) begin
                tx_in_progress <= 1'b0;
            end
            if (wr_rise && txen_sync_r[1] && !sel_sync_r[1]) begin
                tx_byte <= din_s2_r;
                tx_byte_valid <= 1'b1;
            end
        end
    end

    // Position in the frame as the host sees it: 1 while the length
    // high byte stands, 2 for the low byte, then one per payload byte.
    // The read that finds the last position ends the frame.
    assign total = {2'b00, frame_len} + 18'h0_0002;

    // Receive sequencer: gap, then length bytes, then payload
    always @(posedge clk) begin
        if (sys_rst) begin
            state_r <= ST_IDLE;
            gap_r <= 10'h000;
            pos_r <= 18'h0_0000;
            rx_frame_valid <= 1'b0;
            host_byte_bus_out <= 8'h00;
            frame_idx <= 16'h0000;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    gap_r <= 10'h000;
                    // Ignore the request in the cycle of the done pulse:
                    // a source that drops it on done has not yet done so
                    if (frame_ready && !frame_done) begin
                        state_r <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    // Any transmit activity restarts the gap
                    if (tx_in_progress || txen_sync_r[1]) begin
                        gap_r <= 10'h000;
                    end else if (gap_r + 10'h001 < IFG_CYC) begin
                        gap_r <= gap_r + 10'h001;
                    end else begin
                        state_r <= ST_SEND;
                        rx_frame_valid <= 1'b1;
                        pos_r <= 18'h0_0001;
                        host_byte_bus_out <= frame_len[15:8];
                        frame_idx <= 16'h0000;
                    end
                end
                ST_SEND: begin
                    if (rd_rise && !sel_sync_r[1]) begin
                        if (pos_r == total) begin
                            rx_frame_valid <= 1'b0;
                            frame_done <= 1'b1;
                            state_r <= ST_IDLE;
                        end else if (pos_r == 18'h0_0001) begin
                            host_byte_bus_out <= frame_len[7:0];
                            pos_r <= pos_r + 18'h0_0001;
                        end else begin
                            host_byte_bus_out <= frame_byte;
                            frame_idx <= frame_idx + 16'h0001;
                            pos_r <= pos_r + 18'h0_0001;
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                    rx_frame_valid <= 1'b0;
                end
            endcase
        end
    end
endmodule

// [design/hfr_regs.vh]
// Constants for the host buffered-port receive block
`ifndef HFR_REGS_VH
`define HFR_REGS_VH
`define HFR_CLK_HZ 10000000
`define HFR_IFG_NS 960
`define HFR_IFG_CYC ((`HFR_IFG_NS * (`HFR_CLK_HZ / 1000000)) / 1000)
`define HFR_DEB_DEFAULT 8'h03
`define HFR_DEB_W 8
`define HFR_LEN_W 16
`define HFR_MODE_NONE 3'h0
`define HFR_MODE_MII 3'h1
`define HFR_MODE_RMII 3'h2
`define HFR_MODE_USB 3'h3
`define HFR_STRAP_MII 3'h4
`define HFR_STRAP_RMII 3'h5
`define HFR_STRAP_USB 3'h0
`endif

// [design/hfr_strobe_deb.v]
// Link-clock edge detector and strobe debouncer
`timescale 1ns/1ns
`include "hfr_regs.vh"
module hfr_strobe_deb (
    input wire clk,                         // System clock
    input wire sys_rst,                     // Synchronous reset
    input wire host_ref_clock,              // Host reference clock pin
    input wire strobe_n,                    // Raw strobe pin, active low
    input wire [`HFR_DEB_W-1:0] deb_count,  // Debounce length, ref periods
    output reg level_r,                     // Debounced strobe level, 1 = low
    output reg rise_r                       // Pulse on debounced release
);
    reg [1:0] ck_sync_r;
    reg [1:0] st_sync_r;
    reg ck_prev_r;
    reg cand_r;
    reg [`HFR_DEB_W-1:0] cnt_r;
    wire ck_edge;

    // Two-flop synchronisers; only the second stage is read by logic
    always @(posedge clk) begin
        if (sys_rst) begin
            ck_sync_r <= 2'b00;
            st_sync_r <= 2'b11;
        end else begin
            ck_sync_r <= {ck_sync_r[0], host_ref_clock};
            st_sync_r <= {st_sync_r[0], strobe_n};
        end
    end

    assign ck_edge = ck_sync_r[1] & ~ck_prev_r;

    // Level must stay put for deb_count reference edges before it counts
    always @(posedge clk) begin
        if (sys_rst) begin
            ck_prev_r <= 1'b0;
            cand_r <= 1'b0;
            cnt_r <= 8'h00;
            level_r <= 1'b0;
            rise_r <= 1'b0;
        end else begin
            ck_prev_r <= ck_sync_r[1];
            rise_r <= 1'b0;
            if (ck_edge) begin
                if (~st_sync_r[1] != cand_r) begin
                    cand_r <= ~st_sync_r[1];
                    cnt_r <= 8'h01;
                end else if (cnt_r < deb_count) begin
                    cnt_r <= cnt_r + 8'h01;
                end else if (level_r != cand_r) begin
                    level_r <= cand_r;
                    rise_r <= level_r & ~cand_r;
                end
            end
        end
    end
endmodule

// [tb/hfr_rx_port_chk.sv]
// Checker on the receive port pins
`timescale 1ns/1ns
module hfr_chk (
    input wire clk, // Clock
    input wire sys_rst, // Reset
    input wire host_read_strobe_n, // Read
    input wire port_select_n, // Select
    input wire [7:0] host_byte_bus_out, // Byte
    input wire host_byte_bus_oe_n, // Drive
    input wire rx_frame_valid, // Valid
    input wire tx_in_progress, // Tx on
    input wire frame_ready, // Source
    input wire [15:0] frame_len, // Length
    input wire [15:0] frame_idx, // Index
    input wire frame_done, // Done
    input wire [2:0] strap_pins, // Straps
    input wire [2:0] ul_mode // Mode
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    // Pin drive follows raw pins, so no debounce lag here
    a_bus_drive: assert property (host_byte_bus_oe_n ==
        (port_select_n | host_read_strobe_n)) else $error("bus enable");
    a_half_duplex: assert property (!(rx_frame_valid && tx_in_progress))
        else $error("valid with tx");
    a_gap_wait: assert property ($rose(rx_frame_valid) |->
        $past(frame_ready, 10) && !$past(tx_in_progress)) else $error("gap");
    a_len_first: assert property ($rose(rx_frame_valid) |->
        ##[0:1] host_byte_bus_out == frame_len[15:8]) else $error("len hi");
    a_idx_step: assert property ($changed(frame_idx) |->
        frame_idx == $past(frame_idx) + 16'h0001 || frame_idx == 16'h0000)
        else $error("idx step");
    a_done_drop: assert property ($fell(rx_frame_valid) |->
        ##[0:1] frame_done) else $error("done");
    a_tx_idle: assert property ($rose(tx_in_progress) |->
        !$past(rx_frame_valid)) else $error("tx start");
    a_mode_map: assert property (ul_mode != 3'h0 |-> ul_mode ==
        (strap_pins == 3'h4 ? 3'h1 : strap_pins == 3'h5 ? 3'h2 : 3'h3))
        else $error("mode");
    c_frame: cover property ($fell(rx_frame_valid));
    c_tx: cover property ($rose(tx_in_progress));
    c_read: cover property (!host_byte_bus_oe_n);
endmodule
bind hfr_rx_port hfr_chk hfr_chk_inst (.clk(clk), .sys_rst(sys_rst),
    .host_read_strobe_n(host_read_strobe_n), .port_select_n(port_select_n),
    .host_byte_bus_out(host_byte_bus_out),
    .host_byte_bus_oe_n(host_byte_bus_oe_n), .rx_frame_valid(rx_frame_valid),
    .tx_in_progress(tx_in_progress), .frame_ready(frame_ready),
    .frame_len(frame_len), .frame_idx(frame_idx), .frame_done(frame_done),
    .strap_pins(strap_pins), .ul_mode(ul_mode));

// [tb/hfr_host.sv]
// Host model driving the strobes and the data pins
`timescale 1ns/1ns
module hfr_host (
    input wire clk, // Clock
    input wire [7:0] pin_bus, // Resolved pins
    output reg rd_n, // Read strobe
    output reg wr_n, // Write strobe
    output reg sel_n, // Select
    output reg drv_en, // Host drives pins
    output reg [7:0] drv // Host byte
);
    initial begin
        rd_n = 1'b1;
        wr_n = 1'b1;
        sel_n = 1'b1;
        drv_en = 1'b0;
        drv = 8'h00;
    end
    // One strobe; select and data held over the whole pulse
    task strobe(input w, input s, input [7:0] d, input int lo,
        output [7:0] q);
        @(posedge clk);
        sel_n <= s;
        drv <= d;
        drv_en <= w;
        if (w)
            wr_n <= 1'b0;
        else
            rd_n <= 1'b0;
        repeat (lo) @(posedge clk);
        q = pin_bus;
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        // High phase outlasts debounce so the byte is taken
        repeat (48) @(posedge clk);
        sel_n <= 1'b1;
        drv_en <= 1'b0;
    endtask
endmodule

// [tb/testbench.sv]
// Testbench for the buffered host receive port
`timescale 1ns/1ns
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module testbench;
    reg clk = 1'b0;
    reg sys_rst = 1'b1;
    reg ref_clk = 1'b0;
    reg tx_en = 1'b0;
    reg ready = 1'b0;
    reg tx_busy = 1'b0;
    reg [15:0] len = 16'h0000;
    reg [2:0] straps = 3'h4;
    reg [7:0] last = 8'h00;
    reg [7:0] b;
    reg [7:0] deb = 8'h03;
    reg [5:0] tab [0:3];
    wire [7:0] bus_out, tx_byte, drv, pin_bus;
    wire [15:0] idx;
    wire [2:0] mode;
    wire oe_n, valid, tx_ip, done, tx_v, rd_n, wr_n, sel_n, drv_en;
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    int done_cnt = 0;
    int txv_cnt = 0;
    always #50 clk = ~clk;
    initial #137 forever #400 ref_clk = ~ref_clk;
    // Released pins show a changing pattern, never a stale byte
    assign pin_bus = !oe_n ? bus_out : drv_en ? drv : ~last;
    // Count the one-cycle done and write pulses while they stand
    always @(posedge clk) begin
        last <= pin_bus;
        if (done === 1'b1)
            done_cnt++;
        if (tx_v === 1'b1)
            txv_cnt++;
    end
    hfr_rx_port hfr_rx_port_inst (.clk(clk), .sys_rst(sys_rst),
        .host_ref_clock(ref_clk), .host_read_strobe_n(rd_n),
        .host_write_strobe_n(wr_n), .port_select_n(sel_n),
        .tx_session_enable(tx_en), .host_byte_bus_in(pin_bus),
        .host_byte_bus_out(bus_out), .host_byte_bus_oe_n(oe_n),
        .rx_frame_valid(valid), .tx_in_progress(tx_ip),
        .deb_count(deb), .frame_ready(ready), .frame_len(len),
        .frame_byte(8'ha0 + idx[7:0]), .frame_idx(idx), .frame_done(done),
        .tx_byte(tx_byte), .tx_byte_valid(tx_v), .tx_busy(tx_busy),
        .strap_pins(straps), .ul_mode(mode));
    hfr_host hfr_host_inst (.clk(clk), .pin_bus(pin_bus), .rd_n(rd_n),
        .wr_n(wr_n), .sel_n(sel_n), .drv_en(drv_en), .drv(drv));
    task do_reset(input [2:0] s);
        sys_rst <= 1'b1;
        straps <= s;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (5) @(posedge clk);
    endtask
    // Straps are latched once per reset, so each code needs one
    task t_straps;
        tab = '{6'h21, 6'h2a, 6'h03, 6'h38};
        for (int i = 0; i < 4; i++) begin
            do_reset(tab[i][5:3]);
            `CHK(mode, tab[i][2:0])
        end
    endtask
    // Header then payload; bad adds a deselected read and a glitch
    task t_frame(input [15:0] n, input bad);
        int w;
        int d;
        d = done_cnt;
        len <= n;
        ready <= 1'b1;
        for (w = 0; w < 200 && valid !== 1'b1; w++)
            @(posedge clk);
        `CHK(w >= 8 && w < 16, 1'b1)
        if (bad) begin
            hfr_host_inst.strobe(1'b0, 1'b1, 8'h00, 48, b);
            hfr_host_inst.strobe(1'b0, 1'b0, 8'h00, 6, b);
        end
        for (int i = 0; i < n + 2; i++) begin
            // Source lets go before the last read so no second frame starts
            if (i == n + 1)
                ready <= 1'b0;
            hfr_host_inst.strobe(1'b0, 1'b0, 8'h00, 48, b);
            `CHK(b, i == 0 ? n[15:8] : i == 1 ? n[7:0] : 8'ha0 + i - 2)
            `CHK(valid, i < n + 1)
        end
        `CHK(done_cnt - d, 1)
    endtask
    // A transmit session holds off a waiting frame until it ends
    task t_tx;
        tx_en <= 1'b1;
        len <= 16'h0001;
        ready <= 1'b1;
        repeat (5) @(posedge clk);
        `CHK(tx_ip, 1'b1)
        hfr_host_inst.strobe(1'b1, 1'b0, 8'h5c, 48, b);
        `CHK(tx_byte, 8'h5c)
        `CHK(txv_cnt, 1)
        `CHK(valid, 1'b0)
        tx_busy <= 1'b1;
        tx_en <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK(tx_ip, 1'b1)
        tx_busy <= 1'b0;
        for (int k = 0; k < 50 && tx_ip !== 1'b0; k++)
            @(posedge clk);
        `CHK(tx_ip, 1'b0)
        // Last frame runs at the shortest debounce setting
        deb <= 8'h01;
        t_frame(16'h0001, 1'b0);
    endtask
    task end_of_test;
        $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // The run needs under 2000 cycles; a hang is cut off well above
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            error_cnt++;
            end_of_test;
        end
    end
    initial begin
        do_reset(3'h4);
        t_straps;
        t_frame(16'h0000, 1'b0);
        t_frame(16'h0003, 1'b1);
        t_tx;
        end_of_test;
    end
endmodule
